// file: logic/tw_consts.svh
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH
`define TW_CLK_HZ                100000000
`define TW_BUS_HZ                100000
`define TW_TICK_DIV              (`TW_CLK_HZ / (4 * `TW_BUS_HZ))
`define TW_CW_FLAG               7
`define TW_CW_ACK                6
`define TW_CW_STA                5
`define TW_CW_STO                4
`define TW_CW_WC                 3
`define TW_CW_EN                 2
`define TW_CW_IE                 0
`define TW_CTL_RST               8'h00
`define TW_DATA_RST              8'hFF
`define TW_STAT_RST              8'hF8
`define TW_STAT_MASK             8'hF8
`define TW_C_START               8'h08
`define TW_C_RSTART              8'h10
`define TW_C_MTX_SLA_ACK         8'h18
`define TW_C_MTX_SLA_NACK        8'h20
`define TW_DATA_SENT_ACKED_CODE  8'h28
`define TW_C_MTX_DATA_NACK       8'h30
`define TW_C_MRX_SLA_ACK         8'h40
`define TW_C_MRX_SLA_NACK        8'h48
`define TW_C_MRX_DATA_ACK        8'h50
`define TW_C_MRX_DATA_NACK       8'h58
`define TW_C_SRX_SLA_ACK         8'h60
`define TW_C_SRX_DATA_ACK        8'h80
`define TW_C_SRX_DATA_NACK       8'h88
`define TW_C_SRX_STOP            8'hA0
`define TW_C_STX_SLA_ACK         8'hA8
`define TW_C_STX_DATA_ACK        8'hB8
`define TW_C_STX_DATA_NACK       8'hC0
`define TW_C_IDLE                8'hF8
`endif

// file: logic/tw_pkg.sv
package tw_pkg;
  typedef enum logic [2:0] {
    TW_IDLE  = 3'h0,
    TW_START = 3'h1,
    TW_BYTE  = 3'h3,
    TW_HOLD  = 3'h2,
    TW_STOP  = 3'h6,
    TW_SLAVE = 3'h7
  } tw_state_t;

  typedef struct packed {
    logic       ctl_wr;
    logic [7:0] ctl_wdata;
    logic       data_wr;
    logic [7:0] data_wdata;
    logic       presc_wr;
    logic [1:0] presc_wdata;
  } tw_sw_req_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } tw_pins_t;
endpackage : tw_pkg

// file: logic/tw_core.sv
`timescale 1ns/1ps
`include "tw_consts.svh"
module tw_core
  import tw_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire tw_sw_req_t sw_req,
  input  wire logic [6:0] own_addr,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output tw_pins_t        pins,
  output logic [7:0]      control_word_register,
  output logic [7:0]      status_code_register,
  output logic [7:0]      data_byte_register
);
  tw_state_t  state_reg;
  logic [7:0] ctl_reg, data_reg, stat_reg, code_next, tick_cnt_reg;
  logic [3:0] bit_reg;
  logic [1:0] ph_reg;
  logic       master_reg, addr_reg, xmit_reg, ack_reg, slv_reg, busy_reg;
  logic       scl_d_reg, sda_d_reg, scl_oe_reg, sda_oe_reg;
  logic       flag, en, tick, step, scl_rise, scl_fall, start_det, stop_det;
  logic       start_done, stop_done, m_done, s_done, s_stop, flag_set, shift_en, ack_give;

  assign flag       = ctl_reg[`TW_CW_FLAG];
  assign en         = ctl_reg[`TW_CW_EN];
  assign tick       = tick_cnt_reg == 8'(`TW_TICK_DIV - 1);
  // Phase 2 waits for the clock line to really go high
  assign step       = tick && (ph_reg != 2'h2 || scl_in);
  assign scl_rise   = scl_in && !scl_d_reg;
  assign scl_fall   = !scl_in && scl_d_reg;
  assign start_det  = scl_in && scl_d_reg && sda_d_reg && !sda_in;
  assign stop_det   = scl_in && scl_d_reg && !sda_d_reg && sda_in;
  assign start_done = state_reg == TW_START && step && ph_reg == 2'h3;
  assign stop_done  = state_reg == TW_STOP && step && ph_reg == 2'h3;
  assign m_done     = state_reg == TW_BYTE && step && ph_reg == 2'h3 && bit_reg == 4'h8;
  assign s_done     = state_reg == TW_SLAVE && scl_fall && bit_reg == 4'h8
                      && (ack_reg || !addr_reg);
  assign s_stop     = state_reg == TW_SLAVE && stop_det && slv_reg;
  assign flag_set   = start_done || m_done || s_done || s_stop;
  assign shift_en   = bit_reg < 4'h8 && ((state_reg == TW_BYTE && step && ph_reg == 2'h2)
                      || (state_reg == TW_SLAVE && scl_rise));
  assign ack_give   = ctl_reg[`TW_CW_ACK] && (!addr_reg || data_reg[7:1] == own_addr);

  assign pins                  = '{scl_o: 1'b0, scl_oe: scl_oe_reg, sda_o: 1'b0, sda_oe: sda_oe_reg};
  assign control_word_register = ctl_reg;
  assign status_code_register  = stat_reg;
  assign data_byte_register    = data_reg;

  always_comb begin
    code_next = `TW_C_IDLE;
    if (start_done)
      code_next = master_reg ? `TW_C_RSTART : `TW_C_START;
    else if (m_done && addr_reg)
      code_next = data_reg[0] ? (ack_reg ? `TW_C_MRX_SLA_ACK : `TW_C_MRX_SLA_NACK)
                              : (ack_reg ? `TW_C_MTX_SLA_ACK : `TW_C_MTX_SLA_NACK);
    else if (m_done)
      code_next = xmit_reg ? (ack_reg ? `TW_DATA_SENT_ACKED_CODE : `TW_C_MTX_DATA_NACK)
                           : (ack_reg ? `TW_C_MRX_DATA_ACK : `TW_C_MRX_DATA_NACK);
    else if (s_done && addr_reg)
      code_next = data_reg[0] ? `TW_C_STX_SLA_ACK : `TW_C_SRX_SLA_ACK;
    else if (s_done)
      code_next = xmit_reg ? (ack_reg ? `TW_C_STX_DATA_ACK : `TW_C_STX_DATA_NACK)
                           : (ack_reg ? `TW_C_SRX_DATA_ACK : `TW_C_SRX_DATA_NACK);
    else if (s_stop)
      code_next = `TW_C_SRX_STOP;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      tick_cnt_reg <= 8'h00;
    else if (tick)
      tick_cnt_reg <= 8'h00;
    else
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      busy_reg  <= 1'b0;
    end else begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
      if (start_det)
        busy_reg <= 1'b1;
      else if (stop_det)
        busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= `TW_CTL_RST;
    end else begin
      if (stop_done)
        ctl_reg[`TW_CW_STO] <= 1'b0;
      if (sw_req.ctl_wr) begin
        ctl_reg[`TW_CW_ACK] <= sw_req.ctl_wdata[`TW_CW_ACK];
        ctl_reg[`TW_CW_STA] <= sw_req.ctl_wdata[`TW_CW_STA];
        ctl_reg[`TW_CW_STO] <= sw_req.ctl_wdata[`TW_CW_STO];
        ctl_reg[`TW_CW_EN]  <= sw_req.ctl_wdata[`TW_CW_EN];
        ctl_reg[`TW_CW_IE]  <= sw_req.ctl_wdata[`TW_CW_IE];
      end
      if (flag_set)
        ctl_reg[`TW_CW_FLAG] <= 1'b1;
      else if (sw_req.ctl_wr && sw_req.ctl_wdata[`TW_CW_FLAG])
        ctl_reg[`TW_CW_FLAG] <= 1'b0;
      if (sw_req.data_wr)
        ctl_reg[`TW_CW_WC] <= !flag;
    end
  end

  // One register serves software and the bus shifter; software loads it only while the flag is set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      data_reg <= `TW_DATA_RST;
    else if (sw_req.data_wr && flag)
      data_reg <= sw_req.data_wdata;
    else if (shift_en)
      data_reg <= {data_reg[6:0], sda_in};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= `TW_STAT_RST;
    end else begin
      if (flag_set || stop_done)
        stat_reg[7:3] <= code_next[7:3];
      if (sw_req.presc_wr)
        stat_reg[1:0] <= sw_req.presc_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= TW_IDLE;
      ph_reg     <= 2'h0;
      bit_reg    <= 4'h0;
      master_reg <= 1'b0;
      addr_reg   <= 1'b0;
      xmit_reg   <= 1'b0;
      ack_reg    <= 1'b0;
      slv_reg    <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (!en) begin
      state_reg  <= TW_IDLE;
      master_reg <= 1'b0;
      slv_reg    <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      if (step && (state_reg == TW_START || state_reg == TW_BYTE || state_reg == TW_STOP))
        ph_reg <= ph_reg + 2'h1;
      unique case (state_reg)
        TW_IDLE: begin
          ph_reg <= 2'h0;
          if (ctl_reg[`TW_CW_STA] && !flag && !busy_reg) begin
            state_reg <= TW_START;
          end else if (start_det) begin
            state_reg <= TW_SLAVE;
            bit_reg   <= 4'hF;  // Wraps to zero on the fall ending the start
            addr_reg  <= 1'b1;
            xmit_reg  <= 1'b0;
          end
        end
        TW_START: if (step) begin
          unique case (ph_reg)
            2'h0: sda_oe_reg <= 1'b0;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b1;
            2'h3: begin
              scl_oe_reg <= 1'b1;
              master_reg <= 1'b1;
              addr_reg   <= 1'b1;
              xmit_reg   <= 1'b1;
              state_reg  <= TW_HOLD;
            end
          endcase
        end
        TW_BYTE: if (step) begin
          unique case (ph_reg)
            2'h0: begin
              sda_oe_reg <= bit_reg == 4'h8 ? !xmit_reg && ctl_reg[`TW_CW_ACK]
                                            : xmit_reg && !data_reg[7];
              if (bit_reg == 4'h8 && !xmit_reg)
                ack_reg <= ctl_reg[`TW_CW_ACK];
            end
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: if (bit_reg == 4'h8 && xmit_reg) ack_reg <= !sda_in;
            2'h3: begin
              scl_oe_reg <= 1'b1;
              bit_reg    <= bit_reg + 4'h1;
              if (bit_reg == 4'h8) begin
                state_reg <= TW_HOLD;
                addr_reg  <= 1'b0;
                if (addr_reg)
                  xmit_reg <= !data_reg[0];
              end
            end
          endcase
        end
        TW_STOP: if (step) begin
          unique case (ph_reg)
            2'h0: sda_oe_reg <= 1'b1;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b0;
            2'h3: begin
              master_reg <= 1'b0;
              state_reg  <= TW_IDLE;
            end
          endcase
        end
        TW_HOLD: if (!flag) begin
          ph_reg  <= 2'h0;
          bit_reg <= 4'h0;
          if (!master_reg) begin
            state_reg  <= slv_reg ? TW_SLAVE : TW_IDLE;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= slv_reg && xmit_reg && !data_reg[7];
          end else if (ctl_reg[`TW_CW_STO])
            state_reg <= TW_STOP;
          else if (ctl_reg[`TW_CW_STA])
            state_reg <= TW_START;
          else
            state_reg <= TW_BYTE;
        end
        TW_SLAVE: begin
          if (stop_det) begin
            state_reg  <= slv_reg ? TW_HOLD : TW_IDLE;
            slv_reg    <= 1'b0;
            sda_oe_reg <= 1'b0;
          end else if (start_det) begin
            bit_reg  <= 4'hF;
            addr_reg <= 1'b1;
            xmit_reg <= 1'b0;
            slv_reg  <= 1'b0;
          end else if (scl_rise && bit_reg == 4'h8 && xmit_reg) begin
            ack_reg <= !sda_in;
          end else if (scl_fall) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h7 && !xmit_reg) begin
              ack_reg    <= ack_give;
              sda_oe_reg <= ack_give;
            end else if (bit_reg == 4'h8) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= s_done ? TW_HOLD : TW_IDLE;
              scl_oe_reg <= s_done;
              slv_reg    <= s_done;
              addr_reg   <= 1'b0;
              if (addr_reg)
                xmit_reg <= data_reg[0];
            end else begin
              sda_oe_reg <= xmit_reg && bit_reg != 4'h7 && !data_reg[7];
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_flag_suspends: assert property (
    flag && en && state_reg == TW_HOLD |=> state_reg == TW_HOLD)
    else $error("bus moved while flag set");
  chk_code_on_flag: assert property (
    flag_set |=> flag && (stat_reg & `TW_STAT_MASK) == ($past(code_next) & `TW_STAT_MASK))
    else $error("status code missing at flag");
  chk_flag_clear: assert property (
    flag && sw_req.ctl_wr && !flag_set |=> flag == !$past(sw_req.ctl_wdata[`TW_CW_FLAG]))
    else $error("flag clear by write wrong");
  chk_write_collide: assert property (
    sw_req.data_wr && !flag |=> ctl_reg[`TW_CW_WC] && (data_reg == $past(data_reg) || $past(shift_en)))
    else $error("collision not flagged");
  chk_data_acked: assert property (
    m_done && xmit_reg && !addr_reg && ack_reg
    |=> flag && (stat_reg & `TW_STAT_MASK) == `TW_DATA_SENT_ACKED_CODE)
    else $error("data ack code wrong");
  chk_rw_direction: assert property (
    m_done && addr_reg |=> xmit_reg == !$past(data_reg[0]))
    else $error("direction bit misread");
  chk_nine_bits: assert property (
    state_reg == TW_BYTE |-> bit_reg <= 4'h8)
    else $error("packet longer than nine bits");
  chk_ack_drive: assert property (
    m_done && !xmit_reg |-> sda_oe_reg == ack_reg)
    else $error("ack level wrong");
  chk_stop_clears: assert property (
    stop_done && !sw_req.ctl_wr |=> !ctl_reg[`TW_CW_STO] && state_reg == TW_IDLE)
    else $error("stop request not cleared");
  chk_start_waits: assert property (
    state_reg == TW_IDLE && busy_reg |=> state_reg != TW_START)
    else $error("start on busy bus");
  chk_prescale_low: assert property (
    sw_req.presc_wr |=> stat_reg[1:0] == $past(sw_req.presc_wdata) && !stat_reg[2])
    else $error("status layout wrong");

  cov_mtx: cover property (flag_set && code_next == `TW_DATA_SENT_ACKED_CODE);
  cov_mrx: cover property (flag_set && code_next == `TW_C_MRX_DATA_ACK);
  cov_srx: cover property (flag_set && code_next == `TW_C_SRX_DATA_ACK);
  cov_stx: cover property (flag_set && code_next == `TW_C_STX_DATA_ACK);
endmodule : tw_core

// file: tb/tw_slave_model.sv
`timescale 1ns/1ps
// Far-side slave: acks its address, takes or gives bytes, may stretch the clock
module tw_slave_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [6:0] slave_addr,
  input  wire logic [7:0] tx_byte,
  input  wire logic       nack_data,
  input  wire logic       slow,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic [7:0]      rx_byte
);
  logic       scl_q, sda_q, active, is_addr, rd;
  logic [3:0] bitcnt;
  logic [7:0] shift, txsh;
  logic [9:0] stretch;

  // Long enough to hold the clock low past the master's release
  assign scl_oe = (stretch != 10'h000);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {active, is_addr, rd, sda_oe} <= 4'h0;
      {scl_q, sda_q} <= 2'b11;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      txsh <= 8'hFF;
      rx_byte <= 8'h00;
      stretch <= 10'h000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (stretch != 10'h000) stretch <= stretch - 10'h001;
      if (scl && scl_q && sda_q && !sda) begin
        active <= 1'b1;
        is_addr <= 1'b1;
        rd <= 1'b0;
        bitcnt <= 4'hF;
        sda_oe <= 1'b0;
      end else if (scl && scl_q && !sda_q && sda) begin
        active <= 1'b0;
        sda_oe <= 1'b0;
      end else if (active && scl && !scl_q) begin
        if (bitcnt < 4'h8) shift <= {shift[6:0], sda};
        else if (rd && !is_addr && sda) active <= 1'b0;
      end else if (active && !scl && scl_q) begin
        if (slow) stretch <= 10'h320;
        if (bitcnt == 4'h7) begin
          bitcnt <= 4'h8;
          if (is_addr) begin
            if (shift[7:1] == slave_addr) begin
              rd <= shift[0];
              sda_oe <= 1'b1;
            end else begin
              active <= 1'b0;
            end
          end else if (rd) begin
            sda_oe <= 1'b0;
          end else begin
            rx_byte <= shift;
            sda_oe <= !nack_data;
          end
        end else if (bitcnt == 4'h8) begin
          bitcnt <= 4'h0;
          is_addr <= 1'b0;
          sda_oe <= rd & !tx_byte[7];
          txsh <= {tx_byte[6:0], 1'b1};
        end else begin
          bitcnt <= bitcnt + 4'h1;
          if (rd && !is_addr) begin
            sda_oe <= !txsh[7];
            txsh <= {txsh[6:0], 1'b1};
          end
        end
      end
    end
  end
endmodule : tw_slave_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import tw_pkg::*;
  localparam logic [6:0] SLV = 7'h2C;
  localparam logic [7:0] RXB = 8'hC3;
  logic       clk_sys, rst_n, m_scl_oe, m_sda_oe, nack_data, slow, scl, sda;
  logic       b_scl_oe, b_sda_oe, bm_ack;
  logic [6:0] own_addr;
  logic [7:0] ctl, stat, data, rx_byte, got;
  tw_sw_req_t sw_req;
  tw_pins_t   pins;
  int         n_fail, n_compared, cycles;

  // Open-drain lines with pull-up
  assign scl = !pins.scl_oe && !m_scl_oe && !b_scl_oe;
  assign sda = !pins.sda_oe && !m_sda_oe && !b_sda_oe;

  tw_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .sw_req(sw_req), .own_addr(own_addr),
    .scl_in(scl), .sda_in(sda), .pins(pins), .control_word_register(ctl),
    .status_code_register(stat), .data_byte_register(data));
  tw_slave_model partner (.clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sda(sda),
    .slave_addr(SLV), .tx_byte(RXB), .nack_data(nack_data), .slow(slow),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rx_byte(rx_byte));

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 100000) begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end

  task complete_run;
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk8

  task code(input logic [7:0] exp);
    chk8(stat & 8'hF8, exp, "status code");
    chk8({5'h00, stat[2:0]}, 8'h03, "prescaler field");
  endtask : code

  task req(input tw_sw_req_t r);
    @(posedge clk_sys) sw_req <= r;
    @(posedge clk_sys) sw_req <= '0;
    #1;
  endtask : req

  task ctl_w(input logic [7:0] v);
    req({1'b1, v, 12'h000});
  endtask : ctl_w

  task dat_w(input logic [7:0] v);
    req({9'h000, 1'b1, v, 3'b000});
  endtask : dat_w

  task wait_flag;
    int i;
    for (i = 0; i < 30000 && ctl[7] !== 1'b1; i++) @(posedge clk_sys);
    #1;
    chk8({7'h00, ctl[7]}, 8'h01, "flag set");
  endtask : wait_flag

  task xfer(input logic [7:0] d, input logic [7:0] c, input logic [7:0] exp);
    dat_w(d);
    ctl_w(c);
    wait_flag();
    code(exp);
  endtask : xfer

  task stop_bus;
    int i;
    ctl_w(8'h94);
    for (i = 0; i < 5000 && ctl[4] !== 1'b0; i++) @(posedge clk_sys);
    repeat (5) @(posedge clk_sys);
    #1;
    chk8({ctl[7], ctl[4], 4'h0, pins.scl_oe, pins.sda_oe}, 8'h00, "stop done");
    code(8'hF8);
  endtask : stop_bus

  // Far-side master used to put the unit in its slave roles
  task bm_bit(input logic v, output logic r);
    int i;
    @(posedge clk_sys) b_sda_oe <= !v;
    repeat (10) @(posedge clk_sys);
    b_scl_oe <= 1'b0;
    for (i = 0; i < 3000 && scl !== 1'b1; i++) @(posedge clk_sys);
    repeat (10) @(posedge clk_sys);
    r = sda;
    b_scl_oe <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask : bm_bit

  task bm_byte(input logic [7:0] v, input logic ack_drive, output logic [7:0] got_b,
               output logic ack_seen);
    int i;
    logic r;
    for (i = 7; i >= 0; i--) begin
      bm_bit(v[i], r);
      got_b[i] = r;
    end
    bm_bit(!ack_drive, r);
    ack_seen = !r;
  endtask : bm_byte

  task bm_start;
    @(posedge clk_sys) b_sda_oe <= 1'b1;
    repeat (10) @(posedge clk_sys);
    b_scl_oe <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask : bm_start

  task bm_stop;
    @(posedge clk_sys) b_sda_oe <= 1'b1;
    repeat (10) @(posedge clk_sys);
    b_scl_oe <= 1'b0;
    repeat (10) @(posedge clk_sys);
    b_sda_oe <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : bm_stop

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    sw_req = '0;
    own_addr = 7'h15;
    nack_data = 1'b0;
    slow = 1'b0;
    b_scl_oe = 1'b0;
    b_sda_oe = 1'b0;
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk8(ctl, 8'h00, "ctl reset");
    chk8(stat, 8'hF8, "status reset");
    chk8(data, 8'hFF, "data reset");
    req({18'h00000, 1'b1, 2'b11});
    code(8'hF8);
    dat_w(8'h5A);
    chk8({ctl[3], 7'h00}, 8'h80, "write collision");
    chk8(data, 8'hFF, "discarded write");
    ctl_w(8'hA4);
    chk8(ctl, 8'h2C, "start request");
    wait_flag();
    code(8'h08);
    dat_w({SLV, 1'b0});
    chk8({ctl[3], 7'h00}, 8'h00, "collision cleared");
    ctl_w(8'h84);
    wait_flag();
    code(8'h18);
    repeat (1000) @(posedge clk_sys);
    #1;
    chk8({ctl[7], pins.scl_oe, scl, 5'h00}, 8'hC0, "bus held");
    ctl_w(8'h04);
    chk8({ctl[7], 7'h00}, 8'h80, "zero keeps flag");
    xfer(8'hA5, 8'h84, 8'h28);
    chk8(rx_byte, 8'hA5, "byte received");
    @(posedge clk_sys) nack_data <= 1'b1;
    xfer(8'h3C, 8'h84, 8'h30);
    chk8(rx_byte, 8'h3C, "byte received");
    stop_bus();
    @(posedge clk_sys) slow <= 1'b1;
    ctl_w(8'hA4);
    wait_flag();
    code(8'h08);
    xfer({SLV, 1'b1}, 8'h84, 8'h40);
    xfer(8'h00, 8'hC4, 8'h50);
    chk8(data, RXB, "read byte acked");
    xfer(8'h00, 8'h84, 8'h58);
    chk8(data, RXB, "read byte nacked");
    stop_bus();
    @(posedge clk_sys) slow <= 1'b0;
    ctl_w(8'hC4);
    bm_start();
    bm_byte({own_addr, 1'b0}, 1'b0, got, bm_ack);
    chk8({7'h00, bm_ack}, 8'h01, "own address acked");
    wait_flag();
    code(8'h60);
    ctl_w(8'hC4);
    bm_byte(8'h96, 1'b0, got, bm_ack);
    chk8({7'h00, bm_ack}, 8'h01, "slave data acked");
    wait_flag();
    code(8'h80);
    chk8(data, 8'h96, "slave byte received");
    ctl_w(8'hC4);
    bm_stop();
    wait_flag();
    code(8'hA0);
    ctl_w(8'hC4);
    bm_start();
    bm_byte({own_addr, 1'b1}, 1'b0, got, bm_ack);
    wait_flag();
    code(8'hA8);
    dat_w(8'hB4);
    ctl_w(8'hC4);
    bm_byte(8'hFF, 1'b1, got, bm_ack);
    chk8(got, 8'hB4, "slave byte sent");
    wait_flag();
    code(8'hB8);
    ctl_w(8'hC4);
    bm_stop();
    wait_flag();
    code(8'hA0);
    ctl_w(8'hC4);
    chk8({ctl[7], 5'h00, pins.scl_oe, pins.sda_oe}, 8'h00, "slave released");
    complete_run();
  end
endmodule : testbench
